/* File: dv/lpfrz_freeze_control_tb_top.sv */
// lpfrz_freeze_control_tb_top: freeze entry and exit tests.
// assumes the pin comes from this top level, user logic is the model.
`timescale 1ns/1ps
module lpfrz_freeze_control_tb_top;
  logic clk = 1'b0, rst = 1'b1, freeze_pin_n = 1'b1, hk_done, hk_req;
  logic freeze_active, low_static_request, freeze_pin_level, freeze_mode;
  logic [1:0] source_clock, gated_clock;
  logic [7:0] done_delay = 8'h00;
  int errors = 0, n_tests = 0, cycles = 0;
  initial forever #5 clk = ~clk;
  lpfrz_user_model u_user (.clk(clk), .housekeeping_request(hk_req),
    .done_delay(done_delay), .housekeeping_done(hk_done),
    .source_clock(source_clock));
  lpfrz_freeze_control #(.NUM_CLOCKS(2)) dut (.clk(clk), .rst(rst),
    .freeze_pin_n(freeze_pin_n), .housekeeping_done(hk_done),
    .source_clock(source_clock), .gated_clock(gated_clock),
    .housekeeping_request(hk_req), .freeze_active(freeze_active),
    .low_static_request(low_static_request),
    .freeze_pin_level(freeze_pin_level), .freeze_mode(freeze_mode));
  // ************************************************************
  // tasks
  // ************************************************************
  task automatic check(input logic seen, input logic exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  task automatic wait_sig(ref logic sig, input logic lvl, output int n);
    for (n = 0; n < 300 && sig !== lvl; n++) @(negedge clk);
  endtask : wait_sig
  task automatic run_freeze(input logic [7:0] delay);
    int n;
    done_delay = delay;
    freeze_pin_n = 1'b0;
    wait_sig(hk_req, 1'b1, n);
    check(n >= 6, 1'b1);
    check(freeze_active, 1'b0);
    wait_sig(freeze_active, 1'b1, n);
    check(n > delay, 1'b1);
    @(negedge clk);
    check(low_static_request, 1'b1);
    check(freeze_mode, 1'b1);
    check(gated_clock == 2'h0, 1'b1);
    check(freeze_pin_level, 1'b0);
    repeat (50) @(negedge clk);
    check(freeze_active, 1'b1);
    freeze_pin_n = 1'b1;
    wait_sig(freeze_active, 1'b0, n);
    check(n <= 4, 1'b1);
    check(low_static_request, 1'b0);
    check(freeze_mode, 1'b0);
    @(negedge clk);
    check(hk_req, 1'b0);
    // off any source clock edge, so gate output settles before the look
    repeat (2) @(negedge clk);
    #0.2;
    check(gated_clock == source_clock, 1'b1);
    @(negedge clk);
    $display("freeze test done, delay %0d", delay);
  endtask : run_freeze
  // ************************************************************
  // sequence
  // ************************************************************
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      print_verdict();
    end
  end
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    check(hk_req, 1'b0);
    check(freeze_mode, 1'b0);
    check(low_static_request, 1'b0);
    // a short low level must be dropped by the persistence check
    freeze_pin_n = 1'b0;
    #1 freeze_pin_n = 1'b1;
    @(negedge clk);
    freeze_pin_n = 1'b0;
    repeat (3) @(negedge clk);
    freeze_pin_n = 1'b1;
    repeat (10) @(negedge clk);
    check(hk_req, 1'b0);
    check(freeze_mode, 1'b0);
    $display("short pulse test done");
    run_freeze(8'h00);
    run_freeze(8'h14);
    print_verdict();
  end
endmodule : lpfrz_freeze_control_tb_top
bind lpfrz_freeze_control lpfrz_sva #(.NUM_CLOCKS(NUM_CLOCKS)) u_sva (
  .clk(clk), .rst(rst), .freeze_pin_n(freeze_pin_n),
  .housekeeping_done(housekeeping_done), .gated_clock(gated_clock),
  .housekeeping_request(housekeeping_request),
  .freeze_active(freeze_active), .low_static_request(low_static_request),
  .freeze_pin_level(freeze_pin_level), .freeze_mode(freeze_mode));

/* File: dv/lpfrz_sva.sv */
// lpfrz_sva: port checks of the freeze sequencer.
// assumes access block, pin buffer and housekeeping are all present.
`timescale 1ns/1ps
module lpfrz_sva #(
  parameter int unsigned NUM_CLOCKS = 1
) (
  input wire logic                  clk,
  input wire logic                  rst,
  input wire logic                  freeze_pin_n,
  input wire logic                  housekeeping_done,
  input wire logic [NUM_CLOCKS-1:0] gated_clock,
  input wire logic                  housekeeping_request,
  input wire logic                  freeze_active,
  input wire logic                  low_static_request,
  input wire logic                  freeze_pin_level,
  input wire logic                  freeze_mode
);
  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence pin_held_low;
    !freeze_pin_n [*3];
  endsequence
  chk_mode_req: assert property (
    freeze_mode |-> low_static_request) else $error("mode without request");
  chk_req_drop: assert property (
    $fell(low_static_request) |-> !freeze_mode) else $error("mode kept");
  chk_pin_pass: assert property (
    freeze_pin_level == freeze_pin_n) else $error("pin level wrong");
  chk_confirm_pin: assert property (
    $rose(housekeeping_request) |-> $past(!freeze_pin_n, 5) && !freeze_pin_n)
    else $error("request without persistence");
  chk_active_done: assert property (
    $rose(freeze_active) |-> $past(housekeeping_done, 2))
    else $error("active before done");
  chk_active_hk: assert property (
    freeze_active |-> housekeeping_request) else $error("active alone");
  chk_lsr_order: assert property (
    $rose(low_static_request) |-> $past(freeze_active))
    else $error("request before gating");
  chk_gate_off: assert property (
    low_static_request |-> gated_clock == '0) else $error("clock not gated");
  chk_hold_active: assert property (
    pin_held_low ##0 freeze_active |=> freeze_active)
    else $error("active dropped early");
  chk_exit_pin: assert property (
    freeze_active && freeze_pin_n |-> ##[1:4] !freeze_active)
    else $error("exit too slow");
  chk_hk_fall: assert property (
    $fell(freeze_active) |=> !housekeeping_request) else $error("hk kept");
endmodule : lpfrz_sva

/* File: dv/lpfrz_user_model.sv */
// lpfrz_user_model: user logic answering housekeeping, two source clocks.
// assumes the bench sets the answer delay before each freeze.
`timescale 1ns/1ps
module lpfrz_user_model (
  input  wire logic       clk,
  input  wire logic       housekeeping_request,
  input  wire logic [7:0] done_delay,
  output logic            housekeeping_done,
  output logic [1:0]      source_clock
);
  int wait_cnt = 0;
  initial source_clock = 2'h0;
  initial housekeeping_done = 1'b0;
  // fast clocks so the gate must close well inside two system cycles
  always #3 source_clock[0] = ~source_clock[0];
  always #3.5 source_clock[1] = ~source_clock[1];
  // done is a level held until the request drops
  always @(negedge clk) begin
    wait_cnt = housekeeping_request ? wait_cnt + 1 : 0;
    housekeeping_done = housekeeping_request && (wait_cnt > done_delay);
  end
endmodule : lpfrz_user_model

/* File: logic/lpfrz_clock_gate.sv */
// lpfrz_clock_gate: glitch-free gate for one source clock.
// assumes gate_enable_n comes from flops on the system clock.
`timescale 1ns/1ps
module lpfrz_clock_gate (
  input  wire logic source_clock,
  input  wire logic gate_enable_n,
  output logic      gated_clock
);

  logic enable_latch;
  logic global_clock_buffer;

  // ************************************************************
  // latch open while source clock is low
  // ************************************************************
  // holding the enable through the high phase avoids runt pulses
  always_latch begin
    if (!source_clock) begin
      enable_latch = gate_enable_n;
    end
  end

  // stops within one source cycle of the enable falling
  assign global_clock_buffer = source_clock & enable_latch;
  assign gated_clock         = global_clock_buffer;

endmodule : lpfrz_clock_gate

/* File: logic/lpfrz_freeze_control.sv */
// lpfrz_freeze_control: freeze entry and exit sequencer with clock gating.
// assumes freeze_pin comes straight from a top-level port (active low),
// and the hard freeze block is modelled by freeze_mode output.
`timescale 1ns/1ps

module lpfrz_freeze_control #(
  parameter int unsigned NUM_CLOCKS       = 1,
  parameter bit          USE_HOUSEKEEPING = 1'b1,
  parameter bit          USE_ACCESS_BLOCK = 1'b1,
  parameter bit          USE_PIN_BUFFER   = 1'b1
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  freeze_pin_n,
  input  wire logic                  housekeeping_done,
  input  wire logic [NUM_CLOCKS-1:0] source_clock,
  output logic [NUM_CLOCKS-1:0]      gated_clock,
  output logic                       housekeeping_request,
  output logic                       freeze_active,
  output logic                       low_static_request,
  output logic                       freeze_pin_level,
  output logic                       freeze_mode
);

  lpfrz_pkg::lpfrz_regs_type state_reg;
  lpfrz_pkg::lpfrz_regs_type state_next;

  logic pin_asserted;
  logic done_seen;
  logic request_to_block;
  logic [lpfrz_pkg::CNT_W-1:0] filt_count_reg;
  logic pin_filtered_reg;
  logic freeze_pin_buffer;

  function automatic logic [lpfrz_pkg::CNT_W-1:0] count_up(
    input logic [lpfrz_pkg::CNT_W-1:0] value
  );
    count_up = value + 8'h01;
  endfunction : count_up

  // ************************************************************
  // pin buffer and synchroniser
  // ************************************************************
  // single buffer; absent buffer reads as never asserted
  assign freeze_pin_buffer = USE_PIN_BUFFER ? freeze_pin_n : 1'b1;
  assign freeze_pin_level  = freeze_pin_buffer;
  // only the second stage is read downstream
  assign pin_asserted =
    ~state_reg.pin_sync[lpfrz_pkg::SYNC_STAGES-1];

  // ************************************************************
  // housekeeping loop-back
  // ************************************************************
  assign done_seen = USE_HOUSEKEEPING ? housekeeping_done
                                      : state_reg.ctrl.housekeeping_request;

  // ************************************************************
  // sequencer
  // ************************************************************
  always_comb begin
    state_next = state_reg;
    state_next.pin_sync = {state_reg.pin_sync[0], freeze_pin_buffer};
    case (state_reg.state)
      lpfrz_pkg::ST_IDLE: begin
        state_next.count = '0;
        if (pin_asserted) begin
          state_next.state = lpfrz_pkg::ST_CONFIRM;
        end
      end
      lpfrz_pkg::ST_CONFIRM: begin
        if (!pin_asserted) begin
          state_next.state = lpfrz_pkg::ST_IDLE;
        end else if (state_reg.count ==
                     lpfrz_pkg::CNT_W'(lpfrz_pkg::PERSIST_CYCLES - 1)) begin
          state_next.state = lpfrz_pkg::ST_HOUSEKEEP;
          state_next.ctrl.housekeeping_request = 1'b1;
        end else begin
          state_next.count = count_up(state_reg.count);
        end
      end
      lpfrz_pkg::ST_HOUSEKEEP: begin
        if (done_seen) begin
          state_next.state = lpfrz_pkg::ST_GATE;
          state_next.ctrl.gate_enable_n = 1'b0;
        end
      end
      lpfrz_pkg::ST_GATE: begin
        // one cycle lets every gate latch close before the request
        state_next.state = lpfrz_pkg::ST_REQUEST;
        state_next.ctrl.freeze_active = 1'b1;
      end
      lpfrz_pkg::ST_REQUEST: begin
        state_next.ctrl.low_static_request = 1'b1;
        state_next.state = lpfrz_pkg::ST_FROZEN;
      end
      lpfrz_pkg::ST_FROZEN: begin
        if (!pin_asserted) begin
          state_next.state = lpfrz_pkg::ST_RELEASE;
          state_next.ctrl.gate_enable_n = 1'b1;
          state_next.ctrl.freeze_active = 1'b0;
          state_next.ctrl.low_static_request = 1'b0;
        end
      end
      lpfrz_pkg::ST_RELEASE: begin
        state_next.ctrl.housekeeping_request = 1'b0;
        state_next.state = lpfrz_pkg::ST_IDLE;
      end
      default: begin
        state_next.state = lpfrz_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg.state <= lpfrz_pkg::ST_IDLE;
      state_reg.pin_sync <= '1;
      state_reg.count <= '0;
      state_reg.ctrl.housekeeping_request <= 1'b0;
      state_reg.ctrl.gate_enable_n <= lpfrz_pkg::GATE_N_RESET;
      state_reg.ctrl.low_static_request <= 1'b0;
      state_reg.ctrl.freeze_active <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ************************************************************
  // hard freeze block model
  // ************************************************************
  // filter on the raw pin; sampled at clock rate it is the best
  // approximation of the analogue filter available here
  always_ff @(posedge clk) begin
    if (rst) begin
      filt_count_reg   <= '0;
      pin_filtered_reg <= 1'b0;
    end else if (!freeze_pin_buffer == pin_filtered_reg) begin
      filt_count_reg <= '0;
    end else if (filt_count_reg ==
                 lpfrz_pkg::CNT_W'(lpfrz_pkg::GLITCH_CYCLES - 1)) begin
      filt_count_reg   <= '0;
      pin_filtered_reg <= !freeze_pin_buffer;
    end else begin
      filt_count_reg <= count_up(filt_count_reg);
    end
  end

  // missing access block leaves the request permanently high
  assign request_to_block = USE_ACCESS_BLOCK ?
                            state_reg.ctrl.low_static_request : 1'b1;
  // all three terms needed; dropping request ends freeze at once
  assign freeze_mode = USE_PIN_BUFFER & request_to_block &
                       pin_filtered_reg;

  // ************************************************************
  // gated clocks
  // ************************************************************
  for (genvar i = 0; i < NUM_CLOCKS; i++) begin : g_gate
    lpfrz_clock_gate u_gate (
      .source_clock  (source_clock[i]),
      .gate_enable_n (state_reg.ctrl.gate_enable_n),
      .gated_clock   (gated_clock[i])
    );
  end

  assign housekeeping_request = USE_HOUSEKEEPING ?
                                state_reg.ctrl.housekeeping_request : 1'b0;
  assign freeze_active        = state_reg.ctrl.freeze_active;
  assign low_static_request   = state_reg.ctrl.low_static_request;

endmodule : lpfrz_freeze_control

/* File: logic/lpfrz_pkg.sv */
// lpfrz_pkg: shared constants and carrier types for the freeze entry control.
// assumes a single 100 MHz system clock; no bus, all control bits are ports.
package lpfrz_pkg;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int unsigned CLK_PERIOD_PS   = 10000;
  localparam int unsigned GLITCH_WIDTH_PS = 2000;
  // filter width in system clocks, rounded up, never below one
  localparam int unsigned GLITCH_CYCLES_RAW =
    (GLITCH_WIDTH_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned GLITCH_CYCLES =
    (GLITCH_CYCLES_RAW < 1) ? 1 : GLITCH_CYCLES_RAW;
  localparam int unsigned ENTRY_TIME_NS   = 1000;
  // entry time in system clocks, rounded up; not used by the sequencer
  localparam int unsigned ENTRY_CYCLES =
    (ENTRY_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // persistence check of the synchronised pin
  localparam int unsigned PERSIST_CYCLES  = 4;
  localparam int unsigned CNT_W           = 8;

  // ************************************************************
  // sizing and reset values
  // ************************************************************
  localparam int unsigned MAX_CLOCKS      = 17;
  localparam int unsigned SYNC_STAGES     = 2;
  localparam logic        GATE_N_RESET    = 1'b1;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CONFIRM,
    ST_HOUSEKEEP,
    ST_GATE,
    ST_REQUEST,
    ST_FROZEN,
    ST_RELEASE
  } lpfrz_state_type;

  typedef struct packed {
    logic housekeeping_request;
    logic gate_enable_n;
    logic low_static_request;
    logic freeze_active;
  } lpfrz_ctrl_type;

  typedef struct packed {
    lpfrz_state_type  state;
    logic [SYNC_STAGES-1:0] pin_sync;
    logic [CNT_W-1:0] count;
    lpfrz_ctrl_type   ctrl;
  } lpfrz_regs_type;

endpackage : lpfrz_pkg
